// *** core/mft_router_pkg.sv ***
/*
 * Shared constants and carrier types for the multifunction terminal router:
 * register offset, field layout, reset value, selection codes and structs.
 * Assumes a single 32-bit routing word addressed in configuration space.
 */
package mft_router_pkg;

  // register placement and reset image
  localparam logic [7:0] ROUTE_OFFSET = 8'h8C;
  localparam logic [31:0] ROUTE_RESET = 32'h00000000;
  localparam logic [3:0] RSVD_NIBBLE = 4'h0;

  // field positions, one four-bit field per terminal
  localparam int T6_LSB = 24;
  localparam int T5_LSB = 20;
  localparam int T4_LSB = 16;
  localparam int T3_LSB = 12;
  localparam int FIELD_W = 4;
  localparam int ROUTE_W = 28;

  // terminal index inside the four-bit pin vectors
  localparam int PIN_T3 = 0;
  localparam int PIN_T4 = 1;
  localparam int PIN_T5 = 2;
  localparam int PIN_T6 = 3;

  // selection codes
  localparam logic [3:0] CODE_INPUT = 4'h0;
  localparam logic [3:0] CODE_SPECIAL = 4'h1;
  localparam logic [3:0] CODE_GPO = 4'h1;
  localparam logic [3:0] CODE_ALT_IN = 4'h2;
  localparam logic [3:0] CODE_FIRST_IRQ = 4'h2;
  localparam logic [3:0] CODE_VID_STAT = 4'h6;
  localparam logic [3:0] CODE_VID_SEL = 4'h7;
  localparam logic [3:0] CODE_AUDIO = 4'h8;
  localparam logic [3:0] CODE_LED = 4'hC;
  localparam logic [3:0] CODE_RING = 4'hC;
  localparam logic [3:0] CODE_EVENT = 4'hE;

  // internal signals that a terminal may carry
  typedef struct packed {
    logic [15:0] irq_line;
    logic clkrun_out;
    logic clkrun_oe;
    logic serirq_out;
    logic serirq_oe;
    logic gp_output_four;
    logic gp_output_three;
    logic video_port_status;
    logic video_function1_select;
    logic card_audio_pwm;
    logic socket0_activity;
    logic socket1_activity;
    logic general_event_out;
    logic ring_indicate_out;
    logic scl_drive_low;
  } route_src_t;

  // one terminal's drive
  typedef struct packed {
    logic out;
    logic oe;
  } drive_t;

  // whole state of the router
  typedef struct packed {
    logic [ROUTE_W-1:0] route;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic latch_meta;
    logic latch_sync;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [31:0] rdata;
    logic rvalid;
    logic gp_input_four;
    logic gp_input_three;
    logic central_dma_grant;
    logic bus_lock;
    logic clkrun_in;
    logic serirq_in;
    logic serial_bus_mode;
  } router_state_t;

  // codes on terminals 4 and 5 that tap a parallel interrupt line
  function automatic logic is_irq_tap(input logic [3:0] code);
    case (code)
      4'h3, 4'h4, 4'h5, 4'h9, 4'hA, 4'hB, 4'hF: is_irq_tap = 1'b1;
      default: is_irq_tap = 1'b0;
    endcase
  endfunction

endpackage

// *** core/multifunction_terminal_router.sv ***
/*
 * Multifunction terminal router: the routing word in configuration space,
 * its EEPROM preload, pin synchronisers and registered terminal drive.
 * Assumes config accesses and EEPROM words arrive on sys_clk; terminal and
 * latch pins are asynchronous and pass two flip-flops.
 */
// Notes on behaviour
// (RQ1) top four bits read zero, writes ignored
// (RQ2) reset clears word, terminals become inputs
// (RQ3) word answers at 8Ch in both functions
// (RQ4) serial EEPROM may preload the word
// (RQ5) host writes the word once at init
// (RQ6) each field selects one terminal signal
// (RQ7) terminal 6: 0 floats, 1 clock-run
// (RQ8) terminal 6: codes 2..15 route that IRQ
// (RQ9) terminal 5: input, output, DMA grant
// (RQ10) terminal 5: listed codes route parallel IRQs
// (RQ11) terminal 5: video status, select, audio PWM
// (RQ12) terminal 5: socket activity and general event
// (RQ13) terminal 4: input, output, bus lock
// (RQ14) serial bus mode puts clock on 4
// (RQ15) terminal 4: video status, select, audio PWM
// (RQ16) terminal 3: 0 floats, 1 serial interrupts
// (RQ17) terminal 3: codes 2..15 route that IRQ
// (RQ18) output codes drive gp bit, inputs sampled
`timescale 1ns/1ns
module multifunction_terminal_router (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // configuration access
  input wire logic cfg_read,
  input wire logic cfg_write,
  input wire logic [2:0] cfg_function,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // serial eeprom preload
  input wire logic eeprom_load_valid,
  input wire logic [31:0] eeprom_load_data,
  // internal signals offered to the terminals
  input wire mft_router_pkg::route_src_t sources,
  // board terminals, index 0 is terminal 3
  input wire logic [3:0] multi_terminal_in,
  input wire logic latch_terminal,
  output logic [3:0] multi_terminal_out,
  output logic [3:0] multi_terminal_oe,
  // sampled terminal inputs
  output logic gp_input_four,
  output logic gp_input_three,
  output logic central_dma_grant,
  output logic bus_lock,
  output logic clkrun_in,
  output logic serial_interrupt_stream_in,
  output logic serial_bus_mode
);

  localparam int ROUTE_W_L = mft_router_pkg::ROUTE_W;
  mft_router_pkg::router_state_t cur;
  mft_router_pkg::router_state_t next_cur;
  mft_router_pkg::drive_t sel_drive [3:0];
  logic [3:0] code_t6;
  logic [3:0] code_t5;
  logic [3:0] code_t4;
  logic [3:0] code_t3;
  logic [31:0] read_word;
  logic [ROUTE_W_L-1:0] merged;
  logic cfg_sel;

  // address decode shared by reads and writes
  function automatic logic cfg_hits(input logic [2:0] func, input logic [7:0] addr);
    cfg_hits = (func <= 3'h1) && (addr[7:2] == mft_router_pkg::ROUTE_OFFSET[7:2]);
  endfunction

  // byte-lane merge of a config write into the stored fields
  function automatic logic [27:0] merge_bytes(input logic [27:0] old_word,
                                              input logic [31:0] wdata,
                                              input logic [3:0] be);
    logic [27:0] res;
    res = old_word;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    if (be[2]) begin
      res[23:16] = wdata[23:16];
    end
    if (be[3]) begin
      res[27:24] = wdata[27:24];
    end
    merge_bytes = res;
  endfunction

  // field extraction
  assign code_t6 = cur.route[mft_router_pkg::T6_LSB +: mft_router_pkg::FIELD_W];
  assign code_t5 = cur.route[mft_router_pkg::T5_LSB +: mft_router_pkg::FIELD_W];
  assign code_t4 = cur.route[mft_router_pkg::T4_LSB +: mft_router_pkg::FIELD_W];
  assign code_t3 = cur.route[mft_router_pkg::T3_LSB +: mft_router_pkg::FIELD_W];

  // (RQ1) reserved nibble zero
  assign read_word = {mft_router_pkg::RSVD_NIBBLE, cur.route};
  // (RQ3) decode in both functions
  assign cfg_sel = cfg_hits(cfg_function, cfg_addr);
  assign merged = merge_bytes(cur.route, cfg_wdata, cfg_byte_en);

  // (RQ6) one selector per terminal
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_term
      terminal_select #(
        .TERMINAL(gi + 3)
      ) u_sel (
        .code(cur.route[mft_router_pkg::T3_LSB + gi * 4 +: 4]),
        .src(sources),
        .drive(sel_drive[gi])
      );
    end
  endgenerate

  // next-state logic: config port, preload, pin sampling and drive
  always_comb begin
    next_cur = cur;
    next_cur.rvalid = 1'b0;
    // two-stage synchronisers, first stage read only by the second
    next_cur.pin_meta = multi_terminal_in;
    next_cur.pin_sync = cur.pin_meta;
    next_cur.latch_meta = latch_terminal;
    next_cur.latch_sync = cur.latch_meta;
    // (RQ14) latch held low selects serial bus
    next_cur.serial_bus_mode = ~cur.latch_sync;

    // (RQ4) eeprom preload wins over host
    if (eeprom_load_valid) begin
      next_cur.route = eeprom_load_data[ROUTE_W_L-1:0];
    end else if (cfg_write && cfg_sel) begin
      // (RQ1) upper nibble writes dropped
      next_cur.route = merged;
    end

    // (RQ3) read answer one cycle later
    if (cfg_read && cfg_sel) begin
      next_cur.rdata = read_word;
      next_cur.rvalid = 1'b1;
    end

    // registered terminal drive from the current fields
    for (int k = 0; k < 4; k++) begin
      next_cur.pin_out[k] = sel_drive[k].out;
      next_cur.pin_oe[k] = sel_drive[k].oe;
    end
    // (RQ14) serial clock overrides field 4
    if (cur.serial_bus_mode) begin
      next_cur.pin_out[mft_router_pkg::PIN_T4] = 1'b0;
      next_cur.pin_oe[mft_router_pkg::PIN_T4] = sources.scl_drive_low;
    end

    // (RQ18) sample inputs only while selected
    if (code_t5 == mft_router_pkg::CODE_INPUT) begin
      next_cur.gp_input_four = cur.pin_sync[mft_router_pkg::PIN_T5];
    end
    if (code_t4 == mft_router_pkg::CODE_INPUT && !cur.serial_bus_mode) begin
      next_cur.gp_input_three = cur.pin_sync[mft_router_pkg::PIN_T4];
    end
    // (RQ9) grant follows pin when routed
    next_cur.central_dma_grant = (code_t5 == mft_router_pkg::CODE_ALT_IN) &&
                                 cur.pin_sync[mft_router_pkg::PIN_T5];
    // (RQ13) bus lock when routed
    next_cur.bus_lock = (code_t4 == mft_router_pkg::CODE_ALT_IN) && !cur.serial_bus_mode &&
                        cur.pin_sync[mft_router_pkg::PIN_T4];
    // (RQ7) clock-run pin level readback
    next_cur.clkrun_in = (code_t6 == mft_router_pkg::CODE_SPECIAL) &&
                         cur.pin_sync[mft_router_pkg::PIN_T6];
    // (RQ16) serial interrupt stream readback
    next_cur.serirq_in = (code_t3 == mft_router_pkg::CODE_SPECIAL) &&
                         cur.pin_sync[mft_router_pkg::PIN_T3];
  end

  // (RQ2) reset clears routing and floats pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cur <= '0;
      cur.route <= mft_router_pkg::ROUTE_RESET[ROUTE_W_L-1:0];
      // latch idles high; cleared stages would fake serial mode
      cur.latch_meta <= 1'b1;
      cur.latch_sync <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign cfg_rdata = cur.rdata;
  assign cfg_rvalid = cur.rvalid;
  assign multi_terminal_out = cur.pin_out;
  assign multi_terminal_oe = cur.pin_oe;
  assign gp_input_four = cur.gp_input_four;
  assign gp_input_three = cur.gp_input_three;
  assign central_dma_grant = cur.central_dma_grant;
  assign bus_lock = cur.bus_lock;
  assign clkrun_in = cur.clkrun_in;
  assign serial_interrupt_stream_in = cur.serirq_in;
  assign serial_bus_mode = cur.serial_bus_mode;

  // helpers for the checks below
  logic irq_pick6;
  logic irq_pick3;
  logic irq_pick5;
  logic full_write;
  assign irq_pick6 = sources.irq_line[code_t6];
  assign irq_pick3 = sources.irq_line[code_t3];
  assign irq_pick5 = sources.irq_line[code_t5];
  assign full_write = cfg_write && cfg_sel && (cfg_byte_en == 4'hF) && !eeprom_load_valid;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // read data never carries the reserved nibble
  AST_RSVD_READS_ZERO: assert property ( // (RQ1)
    cfg_rvalid |-> cfg_rdata[31:28] == 4'h0)
    else $error("reserved routing bits read nonzero");

  // routing word right after reset is zero, pins float and serial mode is off
  AST_RESET_CLEARS: assert property (@(posedge sys_clk) disable iff (1'b0) // (RQ2)
    reset |=> (cur.route == '0) && (multi_terminal_oe == 4'h0) && !serial_bus_mode)
    else $error("routing word not cleared by reset");

  // full write lands, then after a quiet cycle reads back the same fields
  AST_WRITE_READBACK: assert property ( // (RQ3)
    full_write ##1 (!cfg_write && !eeprom_load_valid) ##1
    (cfg_read && cfg_sel && !cfg_write && !eeprom_load_valid)
    |=> cfg_rvalid && cfg_rdata == {4'h0, $past(cfg_wdata[27:0], 3)})
    else $error("written routing word not read back");

  // read to the word answers next cycle; elsewhere never
  AST_READ_ANSWER: assert property ( // (RQ3)
    cfg_read |=> cfg_rvalid == $past(cfg_sel))
    else $error("read answer mismatch");

  // eeprom preload takes the word
  AST_EEPROM_LOAD: assert property ( // (RQ4)
    eeprom_load_valid |=> cur.route == $past(eeprom_load_data[27:0]))
    else $error("eeprom preload not taken");

  // terminal 6 floats on code 0 and carries the irq on codes 2..15
  AST_T6_MAP: assert property ( // (RQ8)
    (code_t6 >= 4'h2) |=> multi_terminal_out[3] == $past(irq_pick6) && multi_terminal_oe[3])
    else $error("terminal 6 irq routing wrong");

  AST_T6_FLOAT: assert property ( // (RQ7)
    (code_t6 == 4'h0) |=> !multi_terminal_oe[3])
    else $error("terminal 6 driven while reserved");

  // terminal 3 serial stream and irqs
  AST_T3_MAP: assert property ( // (RQ16)
    (code_t3 == 4'h1) |=> multi_terminal_out[0] == $past(sources.serirq_out) &&
                          multi_terminal_oe[0] == $past(sources.serirq_oe))
    else $error("terminal 3 serial stream wrong");

  AST_T3_IRQ: assert property ( // (RQ17)
    (code_t3 >= 4'h2) |=> multi_terminal_out[0] == $past(irq_pick3))
    else $error("terminal 3 irq routing wrong");

  // terminal 5 output, led and irq taps
  AST_T5_GPO: assert property ( // (RQ18)
    (code_t5 == 4'h1) |=> multi_terminal_out[2] == $past(sources.gp_output_four) &&
                          multi_terminal_oe[2])
    else $error("terminal 5 gp output wrong");

  AST_T5_LED: assert property ( // (RQ12)
    (code_t5 == 4'hC) |=> multi_terminal_out[2] ==
                          $past(sources.socket0_activity | sources.socket1_activity))
    else $error("terminal 5 activity led wrong");

  AST_T5_IRQ: assert property ( // (RQ10)
    mft_router_pkg::is_irq_tap(code_t5) |=> multi_terminal_out[2] == $past(irq_pick5))
    else $error("terminal 5 irq routing wrong");

  // serial bus clock owns terminal 4 two edges after latch settles low
  AST_T4_SERIAL: assert property ( // (RQ14)
    serial_bus_mode |=> !multi_terminal_out[1] &&
                        multi_terminal_oe[1] == $past(sources.scl_drive_low))
    else $error("serial clock not on terminal 4");

  AST_T4_AUDIO: assert property ( // (RQ15)
    (code_t4 == 4'h8 && !serial_bus_mode) |=> multi_terminal_out[1] ==
                                              $past(sources.card_audio_pwm))
    else $error("terminal 4 audio routing wrong");

  AST_T4_LOCK: assert property ( // (RQ13)
    (code_t4 == 4'h2 && !serial_bus_mode) ##1 (code_t4 == 4'h2 && !serial_bus_mode)
    |-> !multi_terminal_oe[1])
    else $error("terminal 4 driven while lock input");

  AST_T5_VIDEO: assert property ( // (RQ11)
    (code_t5 == 4'h7) |=> multi_terminal_out[2] == $past(sources.video_function1_select))
    else $error("terminal 5 video select wrong");

  AST_T5_GRANT: assert property ( // (RQ9)
    (code_t5 == 4'h2) |=> !multi_terminal_oe[2])
    else $error("terminal 5 driven while grant input");

  // remaining codes on terminals 6, 5 and 4
  AST_T6_CLKRUN: assert property ( // (RQ7)
    (code_t6 == 4'h1) |=> multi_terminal_out[3] == $past(sources.clkrun_out) &&
                          multi_terminal_oe[3] == $past(sources.clkrun_oe))
    else $error("terminal 6 clock-run routing wrong");

  AST_T5_AUDIO: assert property ( // (RQ11)
    (code_t5 == 4'h8) |=> multi_terminal_out[2] == $past(sources.card_audio_pwm))
    else $error("terminal 5 audio routing wrong");

  AST_T5_EVENT: assert property ( // (RQ12)
    (code_t5 == 4'hE) |=> multi_terminal_out[2] == $past(sources.general_event_out) &&
                          multi_terminal_oe[2])
    else $error("terminal 5 event routing wrong");

  AST_T4_GPO: assert property ( // (RQ18)
    (code_t4 == 4'h1 && !serial_bus_mode) |=> multi_terminal_out[1] ==
                                              $past(sources.gp_output_three))
    else $error("terminal 4 gp output wrong");

  AST_T4_VIDEO: assert property ( // (RQ15)
    (code_t4 == 4'h6 && !serial_bus_mode) |=> multi_terminal_out[1] ==
                                              $past(sources.video_port_status))
    else $error("terminal 4 video status wrong");

  // alternate inputs read zero or hold while not selected
  AST_GP4_HOLD: assert property ( // (RQ18)
    (code_t5 != 4'h0) |=> $stable(gp_input_four))
    else $error("gp input four moved while not selected");

  AST_GRANT_IDLE: assert property ( // (RQ9)
    (code_t5 != 4'h2) |=> !central_dma_grant)
    else $error("grant active while not routed");

  AST_LOCK_SERIAL: assert property ( // (RQ14)
    serial_bus_mode |=> !bus_lock)
    else $error("bus lock active in serial bus mode");

  // main scenarios
  COV_WRITE_THEN_READ: cover property (full_write ##2 (cfg_read && cfg_sel));
  COV_EEPROM_LOAD: cover property (eeprom_load_valid ##1 (code_t6 != 4'h0));
  COV_SERIAL_MODE: cover property (serial_bus_mode && sources.scl_drive_low);
  COV_T3_IRQ: cover property ((code_t3 == 4'hF) ##1 multi_terminal_out[0]);

endmodule

// *** core/terminal_select.sv ***
/*
 * Output selector for one multifunction terminal: turns the four-bit field
 * into the drive level and enable of that terminal.
 * Assumes the caller registers the result and handles serial bus override.
 */
`timescale 1ns/1ns
module terminal_select #(
  parameter int TERMINAL = 3
) (
  // field and sources
  input wire logic [3:0] code,
  input wire mft_router_pkg::route_src_t src,
  // drive result
  output mft_router_pkg::drive_t drive
);

  // pick the selected internal signal; input codes leave the pin floating
  always_comb begin
    drive = '{out: 1'b0, oe: 1'b0};
    if (TERMINAL == 6 || TERMINAL == 3) begin
      if (code == mft_router_pkg::CODE_SPECIAL) begin
        // (RQ7) (RQ16) clock-run or serial stream
        drive.out = (TERMINAL == 6) ? src.clkrun_out : src.serirq_out;
        drive.oe = (TERMINAL == 6) ? src.clkrun_oe : src.serirq_oe;
      end else if (code >= mft_router_pkg::CODE_FIRST_IRQ) begin
        // (RQ8) (RQ17) irq equals code
        drive.out = src.irq_line[code];
        drive.oe = 1'b1;
      end
    end else begin
      drive.oe = 1'b1;
      // (RQ10) listed irq taps
      if (mft_router_pkg::is_irq_tap(code)) begin
        drive.out = src.irq_line[code];
      end else begin
        case (code)
          // (RQ18) gp output bit
          mft_router_pkg::CODE_GPO: begin
            drive.out = (TERMINAL == 5) ? src.gp_output_four : src.gp_output_three;
          end
          // (RQ11) (RQ15) video and audio
          mft_router_pkg::CODE_VID_STAT: begin
            drive.out = src.video_port_status;
          end
          mft_router_pkg::CODE_VID_SEL: begin
            drive.out = src.video_function1_select;
          end
          mft_router_pkg::CODE_AUDIO: begin
            drive.out = src.card_audio_pwm;
          end
          mft_router_pkg::CODE_LED: begin
            // (RQ12) either socket on 5; ring on 4
            drive.out = (TERMINAL == 5) ? (src.socket0_activity | src.socket1_activity)
                                        : src.ring_indicate_out;
          end
          // (RQ12) general event
          mft_router_pkg::CODE_EVENT: begin
            drive.out = src.general_event_out;
          end
          // (RQ9) (RQ13) input codes float
          default: begin
            drive.oe = 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// *** testbench/board_terminal_model.sv ***
/*
 * Board side of the four multifunction terminals: pull-ups, optional
 * external drivers and the wire level fed back to the pin inputs.
 * Assumes the bench never lets a board driver fight the device drive.
 */
`timescale 1ns/1ns
module board_terminal_model (
  // device drive
  input wire logic [3:0] drv_out,
  input wire logic [3:0] drv_oe,
  // external board drivers
  input wire logic [3:0] ext_val,
  input wire logic [3:0] ext_oe,
  // resolved wire level
  output logic [3:0] pin_level
);
  // a released line goes to the pull-up, never keeps its last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (drv_oe[i]) begin
        pin_level[i] = drv_out[i];
      end else if (ext_oe[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule

// *** testbench/multifunction_terminal_router_test.sv ***
/*
 * Self-checking bench for the multifunction terminal router: config
 * accesses, EEPROM preload, every selection code and the pin inputs.
 * Assumes the board model resolves the pins; one 250 MHz clock.
 */
`timescale 1ns/1ns
module multifunction_terminal_router_test;
  // stimulus
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cfg_read = 1'b0;
  logic cfg_write = 1'b0;
  logic [2:0] cfg_function = 3'h0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_byte_en = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic eeprom_load_valid = 1'b0;
  logic [31:0] eeprom_load_data = 32'h0;
  mft_router_pkg::route_src_t sources = 30'h0;
  logic latch_terminal = 1'b1;
  logic [3:0] ext_val = 4'h0;
  logic [3:0] ext_oe = 4'h0;
  // observed
  logic [31:0] cfg_rdata;
  logic cfg_rvalid;
  logic [3:0] pins;
  logic [3:0] pin_out;
  logic [3:0] pin_oe;
  logic gp4, gp3, grant, lock, clkrun, serirq, ser_mode;
  // bookkeeping
  int n_fail = 0;
  int checks = 0;
  int seed = 84;
  int cycles = 0;
  logic [27:0] route_m = 28'h0;
  localparam int LIMIT = 5000;

  always #2 sys_clk = ~sys_clk;

  multifunction_terminal_router multifunction_terminal_router_i (
    .sys_clk(sys_clk), .reset(reset), .cfg_read(cfg_read), .cfg_write(cfg_write),
    .cfg_function(cfg_function), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .eeprom_load_valid(eeprom_load_valid), .eeprom_load_data(eeprom_load_data),
    .sources(sources), .multi_terminal_in(pins), .latch_terminal(latch_terminal),
    .multi_terminal_out(pin_out), .multi_terminal_oe(pin_oe), .gp_input_four(gp4),
    .gp_input_three(gp3), .central_dma_grant(grant), .bus_lock(lock),
    .clkrun_in(clkrun), .serial_interrupt_stream_in(serirq), .serial_bus_mode(ser_mode));

  board_terminal_model board_terminal_model_i (
    .drv_out(pin_out), .drv_oe(pin_oe), .ext_val(ext_val), .ext_oe(ext_oe),
    .pin_level(pins));

  task automatic final_report();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      final_report();
    end
  end

  // inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // drive level only matters while the terminal is enabled
  task automatic chk_drive(input logic [1:0] got, input logic [1:0] exp);
    if (exp[0] === 1'b1) begin
      chk_word({30'h0, got}, {30'h0, exp});
    end else begin
      chk_word({31'h0, got[0]}, 32'h0);
    end
  endtask

  // idle cycle after each access so no strobe is set twice in one step
  task automatic cfg_wr(input logic [2:0] f, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d);
    cfg_function = f;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
    cfg_write = 1'b1;
    step(1);
    cfg_write = 1'b0;
    step(1);
  endtask

  task automatic cfg_rd(input logic [2:0] f, input logic [7:0] a, output logic [31:0] d,
                        output logic v);
    cfg_function = f;
    cfg_addr = a;
    cfg_read = 1'b1;
    step(1);
    d = cfg_rdata;
    v = cfg_rvalid;
    cfg_read = 1'b0;
    step(1);
  endtask

  // expected {level, enable}; t is the pin index, 0 is terminal 3
  function automatic logic [1:0] exp_drive(input int t, input logic [3:0] c,
                                           input mft_router_pkg::route_src_t s,
                                           input logic ser);
    logic o;
    logic e;
    o = 1'b0;
    e = 1'b1;
    if (t == 0 || t == 3) begin
      if (c == 4'h0) begin
        e = 1'b0;
      end else if (c == 4'h1) begin
        o = (t == 3) ? s.clkrun_out : s.serirq_out;
        e = (t == 3) ? s.clkrun_oe : s.serirq_oe;
      end else begin
        o = s.irq_line[c];
      end
    end else begin
      case (c)
        4'h1: o = (t == 2) ? s.gp_output_four : s.gp_output_three;
        4'h3, 4'h4, 4'h5, 4'h9, 4'hA, 4'hB, 4'hF: o = s.irq_line[c];
        4'h6: o = s.video_port_status;
        4'h7: o = s.video_function1_select;
        4'h8: o = s.card_audio_pwm;
        4'hC: o = (t == 2) ? (s.socket0_activity | s.socket1_activity) : s.ring_indicate_out;
        4'hE: o = s.general_event_out;
        default: e = 1'b0;
      endcase
      if (t == 1 && ser) begin
        o = 1'b0;
        e = s.scl_drive_low;
      end
    end
    return {o, e};
  endfunction

  task automatic check_pins(input logic ser);
    for (int t = 0; t < 4; t++) begin
      chk_drive({pin_out[t], pin_oe[t]},
                exp_drive(t, route_m[12 + 4 * t +: 4], sources, ser));
    end
  endtask

  // code i on all lanes below 16, else random word and lanes; random function; then readback and pins
  task automatic rand_write(input int i, input logic ser);
    logic [31:0] w;
    logic [31:0] m;
    logic [31:0] r;
    logic [3:0] be;
    logic v;
    w = $random(seed);
    be = (i < 16) ? 4'hF : 4'($random(seed));
    if (i < 16) begin
      w = {8{4'(i)}};
    end
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    sources = 30'($random(seed));
    cfg_wr(3'($random(seed) & 1), 8'h8C, be, w);
    route_m = (route_m & ~m[27:0]) | (w[27:0] & m[27:0]);
    cfg_rd(3'($random(seed) & 1), 8'h8C, r, v);
    chk_word(r, {4'h0, route_m});
    check_pins(ser);
  endtask

  initial begin
    logic [31:0] r;
    logic v;
    step(4);
    reset = 1'b0;
    chk_word({28'h0, pin_oe}, 32'h0);
    chk_bit(ser_mode, 1'b0);
    cfg_rd(3'h0, 8'h8C, r, v);
    chk_word(r, 32'h0);
    chk_bit(v, 1'b1);
    chk_bit(ser_mode, 1'b0);
    chk_word({28'h0, pin_oe}, 32'h0);
    // top nibble refuses writes, both functions reach the word
    cfg_wr(3'h1, 8'h8C, 4'hF, 32'hFFFFFFFF);
    route_m = 28'hFFFFFFF;
    cfg_rd(3'h0, 8'h8C, r, v);
    chk_word(r, 32'h0FFFFFFF);
    // unmapped function and offset leave the word alone
    cfg_wr(3'h2, 8'h8C, 4'hF, 32'h0);
    cfg_wr(3'h0, 8'h90, 4'hF, 32'h0);
    cfg_rd(3'h0, 8'h90, r, v);
    chk_bit(v, 1'b0);
    cfg_rd(3'h1, 8'h8C, r, v);
    chk_word(r, {4'h0, route_m});
    // every code on every terminal first, then random words and lanes
    for (int i = 0; i < 40; i++) begin
      rand_write(i, 1'b0);
    end
    // EEPROM word collides with a host write and wins
    eeprom_load_data = $random(seed) | 32'hF0000000;
    eeprom_load_valid = 1'b1;
    cfg_wdata = 32'h0;
    cfg_addr = 8'h8C;
    cfg_byte_en = 4'hF;
    cfg_write = 1'b1;
    step(1);
    eeprom_load_valid = 1'b0;
    cfg_write = 1'b0;
    route_m = eeprom_load_data[27:0];
    step(1);
    cfg_rd(3'h0, 8'h8C, r, v);
    chk_word(r, {4'h0, route_m});
    check_pins(1'b0);
    // alternate inputs: t6 clock-run, t5 grant, t4 lock, t3 serial irq
    // host programs the word once for these inputs
    sources = 30'h0;
    cfg_wr(3'h0, 8'h8C, 4'hF, 32'h01221000);
    route_m = 28'h1221000;
    ext_oe = 4'hF;
    ext_val = 4'($random(seed));
    step(4);
    chk_bit(clkrun, ext_val[3]);
    chk_bit(grant, ext_val[2]);
    chk_bit(lock, ext_val[1]);
    chk_bit(serirq, ext_val[0]);
    cfg_wr(3'h0, 8'h8C, 4'hF, 32'h0);
    route_m = 28'h0;
    ext_val = ~ext_val;
    step(4);
    chk_bit(gp4, ext_val[2]);
    chk_bit(gp3, ext_val[1]);
    chk_bit(grant, 1'b0);
    // serial bus mode: terminal 4 becomes the bus clock
    ext_oe = 4'h0;
    latch_terminal = 1'b0;
    step(4);
    chk_bit(ser_mode, 1'b1);
    for (int i = 0; i < 8; i++) begin
      rand_write(16 + i, 1'b1);
    end
    latch_terminal = 1'b1;
    // second reset in mid-run clears the word and the drive
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    chk_word({28'h0, pin_oe}, 32'h0);
    cfg_rd(3'h1, 8'h8C, r, v);
    chk_word(r, 32'h0);
    chk_bit(ser_mode, 1'b0);
    final_report();
  end
endmodule
